// file: src/cas_pkg.sv
// constants for the converter status, event flag and alert block
// assumes a register port driven by an i2c engine elsewhere in the device
// Behaviour
// - live power-good status bit
// - live thermal-shutdown status bit
// - thermal-warning status bit with hysteresis: set by thermal_warn_hi, cleared by thermal_warn_lo
// - status bit 4: 0 cv, 1 cc
// - status bits are live, except the warning bit, which holds its value between the two thresholds
// - flag 7 on shutdown entry, mask bit 4
// - flag 6 on warning entry, mask bit 3
// - flag 5 on current-limit entry
// - flag 3 on output under-voltage
// - flag 2 on shutdown exit, mask bit 4
// - flag 1 on warning exit, mask bit 3
// - flag 0 on power-good rising edge
// - mask bit 4 gates thermal shutdown alerts
// - mask bit 3 gates thermal warning alerts
// - mask bit 2 gates current-limit alerts
// - mask bit 1 gates under-voltage alerts
// - mask bit 0 gates power-good alerts
// - host writes ones to clear; alert released
package cas_pkg;
    localparam logic [7:0] CAS_STATUS_ADDR = 8'h09;
    localparam logic [7:0] CAS_FLAGS_ADDR  = 8'h0a;
    localparam logic [7:0] CAS_MASK_ADDR   = 8'h0b;
    // status bit positions
    localparam int CAS_ST_PG   = 7;
    localparam int CAS_ST_OTP  = 6;
    localparam int CAS_ST_OTW  = 5;
    localparam int CAS_ST_MODE = 4;
    // event flag positions
    localparam int CAS_EV_SD_IN   = 7;
    localparam int CAS_EV_WRN_IN  = 6;
    localparam int CAS_EV_CL_IN   = 5;
    localparam int CAS_EV_CL_OUT  = 4;
    localparam int CAS_EV_UV      = 3;
    localparam int CAS_EV_SD_OUT  = 2;
    localparam int CAS_EV_WRN_OUT = 1;
    localparam int CAS_EV_PG_RISE = 0;
    // mask bit positions
    localparam int CAS_MK_SD  = 4;
    localparam int CAS_MK_WRN = 3;
    localparam int CAS_MK_CL  = 2;
    localparam int CAS_MK_UV  = 1;
    localparam int CAS_MK_PG  = 0;
    localparam logic [7:0] CAS_MASK_RST  = 8'h00;
    localparam logic [7:0] CAS_FLAGS_RST = 8'h00;
    localparam logic [7:0] CAS_MASK_USED = 8'h1f;
endpackage

// file: src/cas_regfile.sv
// mask register store with a three-address read decode and registered read data
// assumes one access per cycle from the register port
`timescale 1ns/1ps
module cas_regfile (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    // mask write
    input  wire logic       mask_we,
    input  wire logic [7:0] mask_wdata,
    // read
    input  wire logic       rd_en,
    input  wire logic [7:0] rd_addr,
    input  wire logic [7:0] status_val,
    input  wire logic [7:0] flags_val,
    output logic      [7:0] mask_q,
    output logic      [7:0] rd_data
);
    import cas_pkg::*;

    logic [7:0] mask_reg,  mask_next;
    logic [7:0] rdata_reg, rdata_next;

    always_comb begin
        mask_next  = mask_reg;
        rdata_next = rdata_reg;
        if (mask_we) begin
            mask_next = mask_wdata & CAS_MASK_USED;
        end
        if (rd_en) begin
            case (rd_addr)
                CAS_STATUS_ADDR: rdata_next = status_val;
                CAS_FLAGS_ADDR:  rdata_next = flags_val;
                CAS_MASK_ADDR:   rdata_next = mask_reg;
                default:         rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            mask_reg  <= CAS_MASK_RST;
            rdata_reg <= 8'h00;
        end else begin
            mask_reg  <= mask_next;
            rdata_reg <= rdata_next;
        end
    end

    assign mask_q  = mask_reg;
    assign rd_data = rdata_reg;
endmodule

// file: src/cas_top.sv
// status, event flags and open-drain alert of the converter
// assumes condition inputs already synchronous to sys_clk
`timescale 1ns/1ps
module cas_top (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    // converter conditions
    input  wire logic       power_good,
    input  wire logic       thermal_shutdown,
    input  wire logic       thermal_warn_hi,
    input  wire logic       thermal_warn_lo,
    input  wire logic       current_limit,
    input  wire logic       output_undervoltage,
    // register port
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // alert pin, open drain
    output logic            alert_pin_o,
    output logic            alert_pin_oe
);
    import cas_pkg::*;

    logic [7:0] status_reg, status_next;
    logic [7:0] flags_reg,  flags_next;
    logic [3:0] prev_reg,   prev_next;
    logic       warn_reg,   warn_next;
    logic       alert_reg,  alert_next;
    logic [7:0] mask_q;
    logic [7:0] set_vec;
    logic [7:0] enable_vec;
    logic       mask_we;

    assign mask_we = reg_wr && (reg_addr == CAS_MASK_ADDR);

    cas_regfile cas_regfile_inst (
        .sys_clk    (sys_clk),
        .nrst       (nrst),
        .mask_we    (mask_we),
        .mask_wdata (reg_wdata),
        .rd_en      (reg_rd),
        .rd_addr    (reg_addr),
        .status_val (status_reg),
        .flags_val  (flags_reg),
        .mask_q     (mask_q),
        .rd_data    (reg_rdata)
    );

    // live status and warning hysteresis
    always_comb begin
        status_next = 8'h00;
        status_next[CAS_ST_PG]   = power_good;
        status_next[CAS_ST_OTP]  = thermal_shutdown;
        status_next[CAS_ST_OTW]  = warn_reg;
        status_next[CAS_ST_MODE] = current_limit;
        warn_next = warn_reg;
        if (thermal_warn_hi) begin
            warn_next = 1'b1;
        end else if (thermal_warn_lo) begin
            warn_next = 1'b0;
        end
        prev_next = {power_good, thermal_shutdown, current_limit, output_undervoltage};
    end

    // event detection on condition edges
    always_comb begin
        set_vec = 8'h00;
        set_vec[CAS_EV_SD_IN]   = thermal_shutdown & ~prev_reg[2];
        set_vec[CAS_EV_WRN_IN]  = warn_next & ~warn_reg;
        set_vec[CAS_EV_CL_IN]   = current_limit & ~prev_reg[1];
        set_vec[CAS_EV_CL_OUT]  = ~current_limit & prev_reg[1];
        set_vec[CAS_EV_UV]      = output_undervoltage & ~prev_reg[0];
        set_vec[CAS_EV_SD_OUT]  = ~thermal_shutdown & prev_reg[2];
        set_vec[CAS_EV_WRN_OUT] = ~warn_next & warn_reg;
        set_vec[CAS_EV_PG_RISE] = power_good & ~prev_reg[3];
    end

    // latched flags, write one clears, set wins
    always_comb begin
        flags_next = flags_reg;
        if (reg_wr && (reg_addr == CAS_FLAGS_ADDR)) begin
            flags_next = flags_reg & ~reg_wdata;
        end
        flags_next = flags_next | set_vec;
    end

    // per-flag alert enables from mask classes
    always_comb begin
        enable_vec = 8'h00;
        enable_vec[CAS_EV_SD_IN]   = ~mask_q[CAS_MK_SD];
        enable_vec[CAS_EV_SD_OUT]  = ~mask_q[CAS_MK_SD];
        enable_vec[CAS_EV_WRN_IN]  = ~mask_q[CAS_MK_WRN];
        enable_vec[CAS_EV_WRN_OUT] = ~mask_q[CAS_MK_WRN];
        enable_vec[CAS_EV_CL_IN]   = ~mask_q[CAS_MK_CL];
        enable_vec[CAS_EV_CL_OUT]  = ~mask_q[CAS_MK_CL];
        enable_vec[CAS_EV_UV]      = ~mask_q[CAS_MK_UV];
        enable_vec[CAS_EV_PG_RISE] = ~mask_q[CAS_MK_PG];
        alert_next = |(flags_reg & enable_vec);
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            status_reg <= 8'h00;
            flags_reg  <= CAS_FLAGS_RST;
            prev_reg   <= 4'h0;
            warn_reg   <= 1'b0;
            alert_reg  <= 1'b0;
        end else begin
            status_reg <= status_next;
            flags_reg  <= flags_next;
            prev_reg   <= prev_next;
            warn_reg   <= warn_next;
            alert_reg  <= alert_next;
        end
    end

    assign alert_pin_o  = 1'b0;
    assign alert_pin_oe = alert_reg;
endmodule

// file: sim/cas_top_props.sv
// assertions on the alert block ports
// assumes no read and write in one cycle
`timescale 1ns/1ps
module cas_top_props
    import cas_pkg::*;
(
    // clock, reset, conditions
    input wire logic       sys_clk, nrst, power_good, thermal_shutdown, current_limit,
    input wire logic       thermal_warn_hi, thermal_warn_lo, output_undervoltage,
    // register port, pin
    input wire logic       reg_wr, reg_rd, alert_pin_oe,
    input wire logic [7:0] reg_addr, reg_wdata, reg_rdata
);
    logic [7:0] mk_reg, mk_next;
    logic       arm_reg;
    wire  [5:0] c = {power_good, thermal_shutdown, current_limit, thermal_warn_hi,
                     thermal_warn_lo, output_undervoltage};
    always_comb begin
        mk_next = (reg_wr && reg_addr == CAS_MASK_ADDR) ? reg_wdata & CAS_MASK_USED : mk_reg;
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            {arm_reg, mk_reg} <= 9'h000;
        end else begin
            {arm_reg, mk_reg} <= {1'b1, mk_next};
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    chk_sd_entry: assert property (
        arm_reg && $rose(thermal_shutdown) && !mk_reg[4] |-> ##2 alert_pin_oe)
        else $error("no alert");
    chk_sd_exit: assert property (
        arm_reg && $fell(thermal_shutdown) && !mk_reg[4] |-> ##2 alert_pin_oe)
        else $error("no alert");
    chk_pg_rise: assert property (
        arm_reg && $rose(power_good) && !mk_reg[0] |-> ##2 alert_pin_oe)
        else $error("no alert");
    chk_limit_edge: assert property (
        arm_reg && $changed(current_limit) && !mk_reg[2] |-> ##2 alert_pin_oe)
        else $error("no alert");
    chk_alert_hold: assert property (
        alert_pin_oe && !$past(reg_wr) |=> alert_pin_oe) else $error("alert dropped");
    chk_clear_release: assert property (
        arm_reg && reg_wr && reg_addr == CAS_FLAGS_ADDR && reg_wdata == 8'hff && $stable(c)
        |-> ##2 !alert_pin_oe) else $error("alert kept");
    chk_mask_read: assert property (
        reg_rd && reg_addr == CAS_MASK_ADDR |=> reg_rdata == $past(mk_reg)) else $error("mask");
    chk_status_read: assert property (
        arm_reg && reg_rd && reg_addr == CAS_STATUS_ADDR |=> {reg_rdata[7:6], reg_rdata[4:0]}
        == {$past(power_good, 2), $past(thermal_shutdown, 2), $past(current_limit, 2), 4'h0})
        else $error("status");
endmodule
bind cas_top cas_top_props cas_top_props_inst (.sys_clk(sys_clk), .nrst(nrst),
    .power_good(power_good), .thermal_shutdown(thermal_shutdown),
    .current_limit(current_limit), .thermal_warn_hi(thermal_warn_hi),
    .thermal_warn_lo(thermal_warn_lo), .output_undervoltage(output_undervoltage),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .alert_pin_oe(alert_pin_oe),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

// file: sim/cas_host_model.sv
// host controller model on the register port
// assumes accesses launched at falling edges
`timescale 1ns/1ps
module cas_host_model
    import cas_pkg::*;
(
    input  wire logic       sys_clk,
    output logic            reg_wr, reg_rd,
    output logic      [7:0] reg_addr, reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge sys_clk) {reg_wr, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk) {reg_rd, reg_addr} = {1'b1, a};
        @(negedge sys_clk) {reg_rd, reg_addr} = {1'b0, ~a};
        @(negedge sys_clk) d = reg_rdata;
    endtask
    task automatic clr;
        wr(CAS_FLAGS_ADDR, 8'hff);
    endtask
endmodule

// file: sim/cas_top_tb.sv
// self-checking bench for the alert block
// assumes host model and checker compiled before
`timescale 1ns/1ps
module cas_top_tb;
    import cas_pkg::*;
    logic sys_clk = 0;
    logic nrst = 0;
    logic [5:0] cn = 6'h00;
    logic [7:0] q, a, d, v;
    logic w, r, od, oe;
    int err_count = 0;
    int num_checks = 0;
    localparam logic [13:0] TB [9] = '{14'h0101, 14'h0380, 14'h0104, 14'h0540, 14'h0902,
                                       14'h1120, 14'h0130, 14'h2108, 14'h0000};
    always #4 sys_clk = ~sys_clk;
    cas_top cas_top_inst (.sys_clk(sys_clk), .nrst(nrst), .power_good(cn[0]),
        .thermal_shutdown(cn[1]), .thermal_warn_hi(cn[2]), .thermal_warn_lo(cn[3]),
        .current_limit(cn[4]), .output_undervoltage(cn[5]), .reg_wr(w), .reg_rd(r),
        .reg_addr(a), .reg_wdata(d), .reg_rdata(q), .alert_pin_o(od), .alert_pin_oe(oe));
    cas_host_model cas_host_model_inst (.sys_clk(sys_clk), .reg_wr(w), .reg_rd(r),
        .reg_addr(a), .reg_wdata(d), .reg_rdata(q));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rchk(input logic [7:0] ad, input logic [7:0] e);
        cas_host_model_inst.rd(ad, v);
        chk($sformatf("reg %h", ad), e, v);
    endtask
    task automatic t_reset;
        rchk(CAS_MASK_ADDR, 8'h00);
        rchk(CAS_FLAGS_ADDR, CAS_FLAGS_RST);
        chk("alert", 8'h00, {7'h0, oe});
        chk("alert drive", 8'h00, {7'h0, od});
    endtask
    task automatic t_status;
        @(negedge sys_clk) cn = 6'h17;
        cas_host_model_inst.wr(CAS_STATUS_ADDR, 8'h00);
        rchk(CAS_STATUS_ADDR, 8'hf0);
        @(negedge sys_clk) cn = 6'h08;
        @(negedge sys_clk);
        rchk(CAS_STATUS_ADDR, 8'h00);
        rchk(8'h0c, 8'h00);
        @(negedge sys_clk) cn = 6'h00;
        cas_host_model_inst.clr();
    endtask
    task automatic t_events(input logic [7:0] m);
        logic [7:0] en;
        en = ~{m[4], m[3], m[2], m[2], m[1], m[4], m[3], m[0]};
        cas_host_model_inst.wr(CAS_MASK_ADDR, m);
        rchk(CAS_MASK_ADDR, m & CAS_MASK_USED);
        for (int i = 0; i < 9; i++) begin
            @(negedge sys_clk) cn = TB[i][13:8];
            rchk(CAS_FLAGS_ADDR, TB[i][7:0]);
            chk("alert", {7'h0, (TB[i][7:0] & en) != 0}, {7'h0, oe});
            if (i != 5) begin
                cas_host_model_inst.clr();
                rchk(CAS_FLAGS_ADDR, 8'h00);
                chk("alert", 8'h00, {7'h0, oe});
            end
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge sys_clk);
        nrst = 1;
        t_reset();
        t_status();
        t_events(8'h00);
        t_events(8'hff);
        t_events(8'h0a);
        @(negedge sys_clk) nrst = 0;
        repeat (2) @(negedge sys_clk);
        nrst = 1;
        t_reset();
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        print_verdict();
    end
endmodule
